// ===== pkg/eep_pkg.sv
// Purpose: shared constants and types of the serial EEPROM slave front end
// Assumes: core clock 125 MHz, bus clock well below a quarter of it
// Notes:   select byte layout, sync vector layout, write-cycle guard
package eep_pkg;

	localparam int unsigned CORE_CLK_MHZ = 125;

	// select byte layout
	localparam int unsigned SEL_TYPE_HI = 7;
	localparam int unsigned SEL_TYPE_LO = 4;
	localparam int unsigned SEL_ADDR_HI = 3;
	localparam int unsigned SEL_ADDR_LO = 1;
	localparam int unsigned SEL_RW      = 0;
	localparam logic        RW_READ     = 1'b1;
	localparam logic [3:0]  TYPE_ID_DEF = 4'h5; // arbitrary value, overridden per product

	// bit counter: 0..7 data bits, 8 acknowledge slot
	localparam logic [3:0] BIT_LAST = 4'h7;
	localparam logic [3:0] BIT_ACK  = 4'h8;

	// synchroniser vector layout
	localparam int unsigned SY_SDA = 0;
	localparam int unsigned SY_SCL = 1;
	localparam int unsigned SY_WP  = 2;
	localparam int unsigned SY_STRAP_LSB = 3;
	localparam int unsigned SY_STRAP_MID = 4;
	localparam int unsigned SY_STRAP_MSB = 5;
	localparam int unsigned SY_TGL = 6;
	localparam int unsigned SYNC_W = 7;

	// cycles the array gets to raise its busy level after the trigger
	localparam logic [3:0] WR_GUARD_CYC = 4'h4;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_SEL,
		ST_ADDR_HI,
		ST_ADDR_LO,
		ST_WRITE,
		ST_READ,
		ST_BUSY
	} eep_state_t;

endpackage

// ===== logic/eep_bit_capture.sv
// Purpose: samples the data line on every rising edge of the bus clock
// Assumes: sclClk is the bus clock pin; it stands still outside frames
// Notes:   each edge flips bitTgl_r; the core reads bitVal_r only after
//          the toggle has crossed, when bitVal_r is long settled
`timescale 1ns/1ps
module eep_bit_capture
	import eep_pkg::*;
(
	input  wire logic sclClk,
	input  wire logic rstSync_b,
	input  wire logic sdaIn,
	output logic      bitVal_r,
	output logic      bitTgl_r
);

	typedef struct packed {
		logic bitVal;
		logic bitTgl;
	} eep_cap_t;

	eep_cap_t r;
	eep_cap_t n;

	always_comb begin
		n        = r;
		n.bitVal = sdaIn;
		n.bitTgl = ~r.bitTgl;
	end

	// reset release is asynchronous to this clock, harmless: both flops
	// only matter once a start has armed the core
	always_ff @(posedge sclClk or negedge rstSync_b) begin
		if (!rstSync_b) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	assign bitVal_r = r.bitVal;
	assign bitTgl_r = r.bitTgl;

endmodule // eep_bit_capture

// ===== logic/eep_front_end.sv
// Purpose: slave-side front end of a two-wire serial EEPROM
// Assumes: pads of straps and write protect carry weak pull-downs
// Notes:   array, address counter and write timing sit outside;
//          they meet this block at memAddr, strobes and writeBusy
// How it works
// - strap msb is compared with select bit 3, lsb with bit 1
// - a floating strap reads as zero when matching
// - write protect high at any point from start to the end of the address blocks array modification
// - a floating write protect reads low, writes permitted
// - protected writes still ack select and address, never data bytes
// - held in reset and standby, ignoring the bus, until reset release
// - reset asserting again resets at once and stops all responses
// - standby is entered after a stop unless a write cycle runs
// - select byte: type in bits 7..4, straps in 3..1, direction in 0
// - bytes travel most significant bit first
// - address is sixteen bits in two bytes, high then low
// - start is a data fall while clock is high
// - outside write cycles watch for start; ignore transfers lacking one
// - stop is a data rise while clock is high; ends communication
// - after a not-acknowledged read byte, stop returns to standby
// - stop ending a write command triggers the internal write cycle
// - after eight bits the receiver drives data low in the ninth pulse
// - received data is sampled on each rising clock edge
// - the data line is only pulled low or released
// - ack select only on type and strap match, else go standby
// - direction bit one reads, zero writes
// - high address byte is sent before low address byte
// - during a write cycle data output is off and nothing answers
`timescale 1ns/1ps
module eep_front_end
	import eep_pkg::*;
#(
	parameter logic [3:0] TYPE_ID = TYPE_ID_DEF
)
(
	input  wire logic        core_clk,
	input  wire logic        rst_b,
	input  wire logic        sclClk,
	input  wire logic        sdaIn,
	output logic             sdaOut,
	output logic             sdaOe,
	input  wire logic        chip_strap_lsb,
	input  wire logic        chip_strap_mid,
	input  wire logic        chip_strap_msb,
	input  wire logic        write_protect_in,
	input  wire logic [7:0]  rdData,
	input  wire logic        writeBusy,
	output logic [15:0]      memAddr,
	output logic             addrLoad,
	output logic [7:0]       wrData,
	output logic             wrStrobe,
	output logic             rdNext,
	output logic             wrCycStart,
	output logic             standby,
	output logic             readActive
);

	typedef struct packed {
		logic [SYNC_W-1:0] sync1;
		logic [SYNC_W-1:0] sync2;
		logic              sclD;
		logic              sdaD;
		logic              tglD;
		eep_state_t        state;
		logic [3:0]        bitCnt;
		logic [7:0]        shReg;
		logic [7:0]        txReg;
		logic [7:0]        addrHi;
		logic [15:0]       memAddr;
		logic [7:0]        wrData;
		logic              ackOk;
		logic              prot;
		logic              wrPend;
		logic              sdaLow;
		logic [3:0]        guard;
		logic              wrStrobe;
		logic              addrLoad;
		logic              rdNext;
		logic              wrCycStart;
	} eep_core_t;

	eep_core_t r;
	eep_core_t n;

	logic [1:0] rstPipe;
	logic       rstSync_b;
	logic       capBit;
	logic       capTgl;

	// reset asserts at once and releases through two flops
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			rstPipe <= 2'h0;
		end else begin
			rstPipe <= {rstPipe[0], 1'b1};
		end
	end
	assign rstSync_b = rstPipe[1];

	eep_bit_capture u_cap (
		.sclClk    (sclClk),
		.rstSync_b (rstSync_b),
		.sdaIn     (sdaIn),
		.bitVal_r  (capBit),
		.bitTgl_r  (capTgl)
	);

	logic       sclS;
	logic       sdaS;
	logic       wpS;
	logic       tglS;
	logic [2:0] strapS;
	logic       startEvt;
	logic       stopEvt;
	logic       sclFall;
	logic       bitEvt;
	logic [7:0] byteNxt;
	logic       selMatch;

	always_comb begin
		sclS     = r.sync2[SY_SCL];
		sdaS     = r.sync2[SY_SDA];
		wpS      = r.sync2[SY_WP];
		tglS     = r.sync2[SY_TGL];
		strapS   = {r.sync2[SY_STRAP_MSB], r.sync2[SY_STRAP_MID], r.sync2[SY_STRAP_LSB]};
		startEvt = r.sclD & sclS & r.sdaD & ~sdaS;
		stopEvt  = r.sclD & sclS & ~r.sdaD & sdaS;
		sclFall  = r.sclD & ~sclS;
		bitEvt   = tglS ^ r.tglD;
		byteNxt  = {r.shReg[6:0], capBit};
		selMatch = (byteNxt[SEL_TYPE_HI:SEL_TYPE_LO] == TYPE_ID)
			&& (byteNxt[SEL_ADDR_HI:SEL_ADDR_LO] == strapS);
	end

	always_comb begin
		n            = r;
		n.wrStrobe   = 1'b0;
		n.addrLoad   = 1'b0;
		n.rdNext     = 1'b0;
		n.wrCycStart = 1'b0;
		n.sync1      = {capTgl, chip_strap_msb, chip_strap_mid, chip_strap_lsb,
			write_protect_in, sclClk, sdaIn};
		n.sync2      = r.sync1;
		n.sclD       = sclS;
		n.sdaD       = sdaS;
		n.tglD       = tglS;

		// protect is caught anywhere from start to the end of the address
		if (r.state == ST_SEL || r.state == ST_ADDR_HI || r.state == ST_ADDR_LO) begin
			n.prot = r.prot | wpS;
		end

		if (r.state == ST_BUSY) begin
			// bus is deaf until the array reports the cycle done
			n.sdaLow = 1'b0;
			if (r.guard != WR_GUARD_CYC) begin
				n.guard = r.guard + 4'h1;
			end else if (!writeBusy) begin
				n.state = ST_IDLE;
			end
		end else if (startEvt) begin
			n.state  = ST_SEL;
			n.bitCnt = 4'h0;
			n.shReg  = 8'h00;
			n.ackOk  = 1'b0;
			n.prot   = wpS;
			n.wrPend = 1'b0;
			n.sdaLow = 1'b0;
		end else if (stopEvt) begin
			n.sdaLow = 1'b0;
			n.bitCnt = 4'h0;
			// only a stop straight after a data acknowledge triggers; the
			// clock rise that precedes the stop may already count one bit
			if (r.state == ST_WRITE && r.bitCnt <= 4'h1 && r.wrPend) begin
				n.state      = ST_BUSY;
				n.wrCycStart = 1'b1;
				n.guard      = 4'h0;
			end else begin
				n.state = ST_IDLE;
			end
			n.wrPend = 1'b0;
		end else if (r.state != ST_IDLE) begin
			if (bitEvt) begin
				if (r.bitCnt != BIT_ACK) begin
					n.bitCnt = r.bitCnt + 4'h1;
					if (r.state != ST_READ) begin
						n.shReg = byteNxt;
					end
					if (r.bitCnt == BIT_LAST) begin
						unique case (r.state)
							ST_SEL: begin
								n.ackOk = selMatch;
							end
							ST_ADDR_HI: begin
								n.addrHi = byteNxt;
								n.ackOk  = 1'b1;
							end
							ST_ADDR_LO: begin
								n.memAddr  = {r.addrHi, byteNxt};
								n.addrLoad = 1'b1;
								n.ackOk    = 1'b1;
							end
							ST_WRITE: begin
								n.ackOk = ~r.prot;
								if (!r.prot) begin
									n.wrData   = byteNxt;
									n.wrStrobe = 1'b1;
									n.wrPend   = 1'b1;
								end
							end
							ST_READ: begin
								n.ackOk = 1'b0;
							end
							default: begin
								n.ackOk = 1'b0;
							end
						endcase
					end
				end else begin
					// ninth rising edge closes the byte
					n.bitCnt = 4'h0;
					unique case (r.state)
						ST_SEL: begin
							if (!r.ackOk) begin
								n.state = ST_IDLE;
							end else if (r.shReg[SEL_RW] == RW_READ) begin
								n.state = ST_READ;
							end else begin
								n.state = ST_ADDR_HI;
							end
						end
						ST_ADDR_HI: begin
							n.state = ST_ADDR_LO;
						end
						ST_ADDR_LO: begin
							n.state = ST_WRITE;
						end
						ST_WRITE: begin
							n.state = ST_WRITE;
						end
						ST_READ: begin
							// master not acknowledging ends the read
							if (capBit) begin
								n.state = ST_IDLE;
							end else begin
								n.rdNext = 1'b1;
							end
						end
						default: begin
							n.state = ST_IDLE;
						end
					endcase
				end
			end

			// data line only changes while the clock is low
			if (sclFall) begin
				if (r.state == ST_READ) begin
					if (r.bitCnt == BIT_ACK) begin
						n.sdaLow = 1'b0;
					end else if (r.bitCnt == 4'h0) begin
						n.txReg  = rdData;
						n.sdaLow = ~rdData[7];
					end else begin
						n.txReg  = {r.txReg[6:0], 1'b0};
						n.sdaLow = ~r.txReg[6];
					end
				end else begin
					n.sdaLow = (r.bitCnt == BIT_ACK) & r.ackOk;
				end
			end
		end else begin
			n.sdaLow = 1'b0;
		end
	end

	// power-on reset holds everything in standby
	always_ff @(posedge core_clk or negedge rstSync_b) begin
		if (!rstSync_b) begin
			r       <= '0;
			r.state <= ST_IDLE;
		end else begin
			r <= n;
		end
	end

	// the line is never driven high, only pulled low or let go
	assign sdaOut     = 1'b0;
	assign sdaOe      = r.sdaLow & (r.state != ST_BUSY);
	assign memAddr    = r.memAddr;
	assign addrLoad   = r.addrLoad;
	assign wrData     = r.wrData;
	assign wrStrobe   = r.wrStrobe;
	assign rdNext     = r.rdNext;
	assign wrCycStart = r.wrCycStart;
	assign standby    = (r.state == ST_IDLE);
	assign readActive = (r.state == ST_READ);

endmodule // eep_front_end

// ===== bench/eep_monitor.sv
// Purpose: port checks of the serial front end
// Assumes: about 16 core cycles per bus clock period
// Notes:   acknowledge windows sized for that ratio
`timescale 1ns/1ps
module eep_monitor (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic sclClk,
	input wire logic sdaIn,
	input wire logic sdaOut,
	input wire logic sdaOe,
	input wire logic write_protect_in,
	input wire logic writeBusy,
	input wire logic addrLoad,
	input wire logic wrStrobe,
	input wire logic wrCycStart,
	input wire logic standby
);
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (!rst_b);
	property p_low; !sdaOut; endproperty
	a_low: assert property (p_low) else $error("data driven high");
	// reset is checked while held, so no disable here
	property p_rst; disable iff (1'b0) !rst_b [*3] |-> standby && !sdaOe; endproperty
	a_rst: assert property (p_rst) else $error("active in reset");
	property p_oe; $rose(sdaOe) |-> !sclClk; endproperty
	a_oe: assert property (p_oe) else $error("drive with clock high");
	property p_adr; addrLoad |-> ##[1:14] sdaOe; endproperty
	a_adr: assert property (p_adr) else $error("address not acked");
	property p_wr; wrStrobe |-> ##[1:14] sdaOe; endproperty
	a_wr: assert property (p_wr) else $error("data not acked");
	property p_wp;
		write_protect_in && $past(write_protect_in, 8) |-> !wrStrobe && !wrCycStart;
	endproperty
	a_wp: assert property (p_wp) else $error("protected write");
	property p_cyc; wrCycStart |=> (!standby && !sdaOe) [*8]; endproperty
	a_cyc: assert property (p_cyc) else $error("write cycle not quiet");
	property p_stop;
		$rose(sdaIn) && sclClk && $past(sclClk) && !writeBusy
			|-> ##[1:6] (standby || wrCycStart);
	endproperty
	a_stop: assert property (p_stop) else $error("stop ignored");
endmodule // eep_monitor

// ===== bench/eep_mstr.sv
// Purpose: two-wire bus master model
// Assumes: data line pulled up, a released line reads high
// Notes:   clock rests high between frames
`timescale 1ns/1ps
module eep_mstr (
	output logic      sclClk,
	output logic      sdaPull,
	input  wire logic sdaLine
);
	localparam realtime Q = 31.25;
	initial begin
		sclClk = 1'b1;
		sdaPull = 1'b0;
	end
	task automatic send_bit(input logic b, output logic r);
		sdaPull = !b;
		#Q sclClk = 1'b1;
		#(2*Q) r = sdaLine;
		sclClk = 1'b0;
		#Q;
	endtask
	task automatic start_cond();
		sdaPull = 1'b0;
		#Q sclClk = 1'b1;
		#Q sdaPull = 1'b1;
		#Q sclClk = 1'b0;
		#Q;
	endtask
	task automatic stop_cond();
		sdaPull = 1'b1;
		#Q sclClk = 1'b1;
		#Q sdaPull = 1'b0;
		#(2*Q);
	endtask
	// a byte msb first, then the acknowledge slot
	task automatic xfer9(input logic [8:0] d, output logic [8:0] q);
		for (int i = 8; i >= 0; i--) begin
			send_bit(d[i], q[i]);
		end
	endtask
endmodule // eep_mstr

// ===== bench/tb_eep_front_end.sv
// Purpose: self-checking bench of the front end
// Assumes: 125 ns bus clock, 8 ns core clock
// Notes:   write cycle faked by a busy counter
`timescale 1ns/1ps
module tb_eep_front_end;
	import eep_pkg::*;
	localparam logic [3:0] TID = 4'hC; // arbitrary type code
	logic        core_clk = 1'b0;
	logic        rst_b;
	logic        write_protect_in = 1'b0;
	logic [2:0]  straps = 3'h0;
	logic [7:0]  rdData = 8'h00;
	logic [7:0]  wrData, lastWr, s, d;
	logic [15:0] memAddr, lastAddr, ad;
	logic [8:0]  q;
	logic        sclClk, sdaIn, sdaOut, sdaOe, sdaPull, writeBusy, addrLoad;
	logic        wrStrobe, rdNext, wrCycStart, standby, readActive;
	int          error_cnt, check_count, wrCnt, cycCnt, rdCnt, busyCnt, seed, c0;
	always #4 core_clk = !core_clk;
	assign sdaIn = !(sdaOe || sdaPull);
	assign writeBusy = busyCnt != 0;
	eep_front_end #(.TYPE_ID(TID)) eep_front_end_inst (
		.core_clk, .rst_b, .sclClk, .sdaIn, .sdaOut, .sdaOe, .rdData,
		.chip_strap_lsb(straps[0]), .chip_strap_mid(straps[1]),
		.chip_strap_msb(straps[2]), .write_protect_in, .writeBusy, .memAddr,
		.addrLoad, .wrData, .wrStrobe, .rdNext, .wrCycStart, .standby, .readActive
	);
	eep_mstr eep_mstr_inst (.sclClk, .sdaPull, .sdaLine(sdaIn));
	always @(posedge core_clk) begin
		if (addrLoad) lastAddr <= memAddr;
		if (wrStrobe) lastWr <= wrData;
		if (rdNext) rdData <= rdData + 8'h01;
		wrCnt <= wrCnt + int'(wrStrobe === 1'b1);
		cycCnt <= cycCnt + int'(wrCycStart === 1'b1);
		rdCnt <= rdCnt + int'(rdNext === 1'b1);
		busyCnt <= wrCycStart ? 250 : busyCnt - int'(busyCnt > 0);
	end
	task automatic chk(input string n, input logic [15:0] v, input logic [15:0] e);
		check_count++;
		if (v !== e) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", n, e, v);
		end
	endtask
	task automatic tally_and_finish();
		$display("%0d checks, %0d errors", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// sends a byte and compares the acknowledge
	task automatic wa(input string n, input logic [7:0] b, input logic e);
		logic [8:0] r;
		eep_mstr_inst.xfer9({b, 1'b1}, r);
		chk(n, 16'(!r[0]), 16'(e));
	endtask
	initial begin
		rst_b = 1'b0;
		seed = 31530;
		repeat (20) @(posedge core_clk);
		rst_b <= 1'b1;
		repeat (6) @(posedge core_clk);
		s = {TID, 3'b000, 1'b0};
		for (int k = 0; k < 5; k++) begin
			eep_mstr_inst.start_cond();
			wa("sel", k < 4 ? s ^ (8'h02 << k) : s, k == 4);
			eep_mstr_inst.stop_cond();
		end
		$display("select decode done");
		for (int t = 0; t < 4; t++) begin
			@(posedge core_clk);
			straps <= 3'($random(seed));
			write_protect_in <= t[0];
			repeat (4) @(posedge core_clk);
			s = {TID, straps, 1'b0};
			ad = 16'($random(seed));
			d = 8'($random(seed));
			c0 = wrCnt;
			eep_mstr_inst.start_cond();
			wa("sel ack", s, 1'b1);
			wa("hi ack", ad[15:8], 1'b1);
			wa("lo ack", ad[7:0], 1'b1);
			chk("addr", lastAddr, ad);
			wa("data ack", d, !t[0]);
			chk("strobes", 16'(wrCnt - c0), 16'(!t[0]));
			if (!t[0]) chk("wr data", 16'(lastWr), 16'(d));
			c0 = cycCnt;
			eep_mstr_inst.stop_cond();
			repeat (6) @(posedge core_clk);
			chk("trigger", 16'(cycCnt - c0), 16'(!t[0]));
			if (!t[0]) begin
				eep_mstr_inst.start_cond();
				wa("busy ack", s, 1'b0);
				repeat (250) @(posedge core_clk);
				eep_mstr_inst.stop_cond();
				repeat (6) @(posedge core_clk);
			end
			chk("standby", 16'(standby), 16'h1);
			$display("write pass %0d done", t);
		end
		s[0] = 1'b1;
		@(posedge core_clk);
		rdData <= 8'($random(seed));
		eep_mstr_inst.start_cond();
		for (int k = 0; k < 4; k++) eep_mstr_inst.send_bit(1'b0, q[0]);
		eep_mstr_inst.start_cond();
		wa("rd sel", s, 1'b1);
		chk("rd active", 16'(readActive), 16'h1);
		d = rdData;
		c0 = rdCnt;
		eep_mstr_inst.xfer9(9'h1FE, q);
		chk("rd byte", 16'(q[8:1]), 16'(d));
		eep_mstr_inst.xfer9(9'h1FF, q);
		chk("rd next", 16'(q[8:1]), 16'(d + 8'h01));
		chk("rd acks", 16'(rdCnt - c0), 16'h1);
		eep_mstr_inst.stop_cond();
		repeat (6) @(posedge core_clk);
		chk("rd standby", 16'(standby), 16'h1);
		$display("read done");
		@(posedge core_clk);
		rdData <= 8'h3C;
		eep_mstr_inst.start_cond();
		wa("rd sel 2", s, 1'b1);
		repeat (2) @(posedge core_clk);
		chk("rd drive", 16'(sdaOe), 16'h1);
		rst_b <= 1'b0;
		repeat (2) @(posedge core_clk);
		chk("rst oe", 16'(sdaOe), 16'h0);
		chk("rst standby", 16'(standby), 16'h1);
		eep_mstr_inst.start_cond();
		wa("rst ack", s, 1'b0);
		eep_mstr_inst.stop_cond();
		@(posedge core_clk);
		rst_b <= 1'b1;
		repeat (6) @(posedge core_clk);
		$display("reset done");
		tally_and_finish();
	end
	initial begin
		#400000;
		error_cnt++;
		tally_and_finish();
	end
endmodule // tb_eep_front_end
bind eep_front_end eep_monitor eep_monitor_inst (
	.core_clk, .rst_b, .sclClk, .sdaIn, .sdaOut, .sdaOe, .write_protect_in,
	.writeBusy, .addrLoad, .wrStrobe, .wrCycStart, .standby
);
